// ---- accr_pkg.sv ----
// Package with register map, field layout and reset values of the channel calibration bank
package accr_pkg;

    // ------------------------------------------------------------
    // Register indices (word addresses)
    // ------------------------------------------------------------
    localparam logic [5:0] CHAN4_SETUP_IDX = 6'h1d;
    localparam logic [5:0] CHAN4_OFFSET_HIGH_IDX = 6'h1e;
    localparam logic [5:0] CHAN4_OFFSET_LOW_IDX = 6'h1f;
    localparam logic [5:0] CHAN4_GAIN_HIGH_IDX = 6'h20;
    localparam logic [5:0] CHAN4_GAIN_LOW_IDX = 6'h21;
    localparam logic [5:0] CHAN5_SETUP_IDX = 6'h22;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int PHASE_LSB = 6;
    localparam int PHASE_W = 10;
    localparam int DC_OFF_BIT = 2;
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 2;
    localparam int LOW_BYTE_LSB = 8;
    localparam logic [15:0] SETUP_WMASK = 16'hffc7;
    localparam logic [15:0] LOW_WMASK = 16'hff00;
    localparam logic [15:0] FULL_WMASK = 16'hffff;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] SETUP_RST = 16'h0000;
    localparam logic [15:0] OFFSET_HIGH_RST = 16'h0000;
    localparam logic [15:0] OFFSET_LOW_RST = 16'h0000;
    localparam logic [15:0] GAIN_HIGH_RST = 16'h8000;
    localparam logic [15:0] GAIN_LOW_RST = 16'h0000;

    // Input source selections
    typedef enum logic [1:0] {
        ACCR_SEL_PINS = 2'b00,
        ACCR_SEL_SHORT = 2'b01,
        ACCR_SEL_POS_TEST = 2'b10,
        ACCR_SEL_NEG_TEST = 2'b11
    } accr_sel_t;

endpackage

// ---- accr_word_reg.sv ----
// One 16-bit register word with a write mask and reset value
`timescale 1ns/1ps
module accr_word_reg #(
    parameter logic [15:0] RST_VAL = 16'h0000,
    parameter logic [15:0] WMASK = 16'hffff
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] q_o
);

    typedef struct packed {
        logic [15:0] word;
    } accr_word_state_t;

    accr_word_state_t st_q;
    accr_word_state_t st_d;

    // Masked bits keep their reset value forever, so reserved bits read zero
    always_comb
    begin
        st_d = st_q;
        if (wr_i)
        begin
            st_d.word = (wdata_i & WMASK) | (RST_VAL & ~WMASK); // RULE_12
        end
    end

    // State register
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_q.word <= RST_VAL;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign q_o = st_q.word;

endmodule

// ---- accr_setup_decode.sv ----
// Splits a channel setup word into its phase, filter and input select fields
`timescale 1ns/1ps
module accr_setup_decode (
    input wire logic [15:0] setup_i,
    output logic [9:0] phase_delay_o,
    output logic dc_filter_off_o,
    output logic [1:0] input_select_o
);

    // Pure field extraction; the word itself comes from a flip-flop
    assign phase_delay_o = setup_i[accr_pkg::PHASE_LSB +: accr_pkg::PHASE_W]; // RULE_01
    assign dc_filter_off_o = setup_i[accr_pkg::DC_OFF_BIT]; // RULE_03
    assign input_select_o = setup_i[accr_pkg::SEL_LSB +: accr_pkg::SEL_W]; // RULE_04

endmodule

// ---- accr_regs.sv ----
// Channel 4/5 configuration and calibration register bank on an Avalon-MM slave
// What this block does
// RULE_01: Phase delay is a 10-bit two's-complement field in setup bits 15 to 6.
// RULE_02: Setup bits 5 to 3 are read-only and always read zero.
// RULE_03: Setup bit 2 disables the channel DC filter; clear follows global setting.
// RULE_04: Setup bits 1 to 0 pick pins, shorted, positive or negative test.
// RULE_05: Offset high word holds offset bits 23 to 8, fully writable, reset zero.
// RULE_06: Offset low word holds offset bits 7 to 0 in its upper byte.
// RULE_07: Gain is 24-bit unsigned, high word holds gain bits 23 to 8.
// RULE_08: Gain high word at 20h resets to 8000h for unity gain.
// RULE_09: Gain low word upper byte holds gain bits 7 to 0, lower byte zero.
// RULE_10: Channel 4 setup at 1Dh resets zero; 1Eh, 1Fh, 21h reset zero.
// RULE_11: Channel 5 setup at 22h matches channel 4 setup layout and reset.
// RULE_12: Writes to reserved bits do nothing; they still read zero later.
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
module accr_regs (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [1:0] avs_response_o,
    input wire logic global_dc_filter_setting_i,
    output logic [9:0] chan4_phase_delay_o,
    output logic chan4_dc_filter_off_o,
    output logic chan4_dc_filter_active_o,
    output logic [1:0] chan4_input_select_o,
    output logic [23:0] chan4_offset_o,
    output logic [23:0] chan4_gain_o,
    output logic [9:0] chan5_phase_delay_o,
    output logic chan5_dc_filter_off_o,
    output logic chan5_dc_filter_active_o,
    output logic [1:0] chan5_input_select_o
);

    // ------------------------------------------------------------
    // Bus state
    // ------------------------------------------------------------
    // One wait cycle per access: a request is answered on its second edge,
    // which gives registered read data without a read pipeline.
    typedef enum logic [0:0] {
        ACCR_IDLE = 1'b0,
        ACCR_DONE = 1'b1
    } accr_bus_t;

    typedef struct packed {
        accr_bus_t bus;
        logic [31:0] rdata;
        logic [1:0] resp;
    } accr_state_t;

    accr_state_t st_q;
    accr_state_t st_d;

    logic [5:0] word_idx;
    logic addr_ok;
    logic hit_s4;
    logic hit_oh;
    logic hit_ol;
    logic hit_gh;
    logic hit_gl;
    logic hit_s5;
    logic wr_fire;
    logic [15:0] wmerge;
    logic [15:0] s4_q;
    logic [15:0] oh_q;
    logic [15:0] ol_q;
    logic [15:0] gh_q;
    logic [15:0] gl_q;
    logic [15:0] s5_q;
    logic [15:0] rmux;

    // Word index from a byte address; misaligned addresses are unmapped
    function automatic logic [5:0] to_index(input logic [7:0] addr);
        to_index = addr[7:2];
    endfunction

    // Byte-enable merge of new write data over the current word
    function automatic logic [15:0] merge_be(input logic [15:0] cur, input logic [15:0] wd,
                                             input logic [1:0] be);
        logic [15:0] res;
        res = cur;
        if (be[0])
        begin
            res[7:0] = wd[7:0];
        end
        if (be[1])
        begin
            res[15:8] = wd[15:8];
        end
        merge_be = res;
    endfunction

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign word_idx = to_index(avs_address_i);
    assign hit_s4 = (word_idx == accr_pkg::CHAN4_SETUP_IDX); // RULE_10
    assign hit_oh = (word_idx == accr_pkg::CHAN4_OFFSET_HIGH_IDX);
    assign hit_ol = (word_idx == accr_pkg::CHAN4_OFFSET_LOW_IDX);
    assign hit_gh = (word_idx == accr_pkg::CHAN4_GAIN_HIGH_IDX); // RULE_08
    assign hit_gl = (word_idx == accr_pkg::CHAN4_GAIN_LOW_IDX);
    assign hit_s5 = (word_idx == accr_pkg::CHAN5_SETUP_IDX); // RULE_11
    assign addr_ok = (avs_address_i[1:0] == 2'b00) && (hit_s4 || hit_oh || hit_ol || hit_gh || hit_gl || hit_s5);

    // Write takes effect on the edge where waitrequest is low
    assign wr_fire = avs_write_i && (st_q.bus == ACCR_DONE) && addr_ok;

    // Read multiplexer over the stored words
    always_comb
    begin
        rmux = 16'h0000;
        if (hit_s4)
        begin
            rmux = s4_q;
        end
        else if (hit_oh)
        begin
            rmux = oh_q;
        end
        else if (hit_ol)
        begin
            rmux = ol_q;
        end
        else if (hit_gh)
        begin
            rmux = gh_q;
        end
        else if (hit_gl)
        begin
            rmux = gl_q;
        end
        else if (hit_s5)
        begin
            rmux = s5_q;
        end
    end

    // Merge data from the addressed word; upper byte lanes are not stored
    assign wmerge = merge_be(rmux, avs_writedata_i[15:0], avs_byteenable_i[1:0]);

    // ------------------------------------------------------------
    // Register words
    // ------------------------------------------------------------
    // Masks hold reserved bits at zero whatever is written
    accr_word_reg #(.RST_VAL(accr_pkg::SETUP_RST), .WMASK(accr_pkg::SETUP_WMASK)) u_s4 ( // RULE_02
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .wr_i(wr_fire && hit_s4),
        .wdata_i(wmerge),
        .q_o(s4_q)
    );

    accr_word_reg #(.RST_VAL(accr_pkg::OFFSET_HIGH_RST), .WMASK(accr_pkg::FULL_WMASK)) u_oh ( // RULE_05
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .wr_i(wr_fire && hit_oh),
        .wdata_i(wmerge),
        .q_o(oh_q)
    );

    accr_word_reg #(.RST_VAL(accr_pkg::OFFSET_LOW_RST), .WMASK(accr_pkg::LOW_WMASK)) u_ol ( // RULE_06
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .wr_i(wr_fire && hit_ol),
        .wdata_i(wmerge),
        .q_o(ol_q)
    );

    accr_word_reg #(.RST_VAL(accr_pkg::GAIN_HIGH_RST), .WMASK(accr_pkg::FULL_WMASK)) u_gh ( // RULE_08
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .wr_i(wr_fire && hit_gh),
        .wdata_i(wmerge),
        .q_o(gh_q)
    );

    accr_word_reg #(.RST_VAL(accr_pkg::GAIN_LOW_RST), .WMASK(accr_pkg::LOW_WMASK)) u_gl ( // RULE_09
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .wr_i(wr_fire && hit_gl),
        .wdata_i(wmerge),
        .q_o(gl_q)
    );

    accr_word_reg #(.RST_VAL(accr_pkg::SETUP_RST), .WMASK(accr_pkg::SETUP_WMASK)) u_s5 ( // RULE_11
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .wr_i(wr_fire && hit_s5),
        .wdata_i(wmerge),
        .q_o(s5_q)
    );

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    // Idle accepts the request, done answers it; a dropped request returns to idle
    always_comb
    begin
        st_d = st_q;
        case (st_q.bus)
            ACCR_IDLE:
            begin
                if (avs_read_i || avs_write_i)
                begin
                    st_d.bus = ACCR_DONE;
                    st_d.rdata = {16'h0000, rmux};
                    st_d.resp = addr_ok ? 2'b00 : 2'b11; // Decode error for unmapped words
                    if (!avs_read_i || !addr_ok) // Misaligned reads must not leak the aliased word
                    begin
                        st_d.rdata = 32'h0000_0000;
                    end
                end
            end
            ACCR_DONE:
            begin
                st_d.bus = ACCR_IDLE;
            end
            default:
            begin
                st_d.bus = ACCR_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_q <= '{bus: ACCR_IDLE, rdata: 32'h0000_0000, resp: 2'b00};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign avs_waitrequest_o = (st_q.bus != ACCR_DONE);
    assign avs_readdata_o = st_q.rdata;
    assign avs_response_o = st_q.resp;

    // ------------------------------------------------------------
    // Channel outputs
    // ------------------------------------------------------------
    accr_setup_decode u_dec4 ( // RULE_01
        .setup_i(s4_q),
        .phase_delay_o(chan4_phase_delay_o),
        .dc_filter_off_o(chan4_dc_filter_off_o),
        .input_select_o(chan4_input_select_o)
    );

    accr_setup_decode u_dec5 ( // RULE_11
        .setup_i(s5_q),
        .phase_delay_o(chan5_phase_delay_o),
        .dc_filter_off_o(chan5_dc_filter_off_o),
        .input_select_o(chan5_input_select_o)
    );

    // The local bit only ever turns the filter off, never on
    assign chan4_dc_filter_active_o = global_dc_filter_setting_i && !chan4_dc_filter_off_o; // RULE_03
    assign chan5_dc_filter_active_o = global_dc_filter_setting_i && !chan5_dc_filter_off_o; // RULE_03

    // Calibration words reassembled; reserved low bytes are dropped
    assign chan4_offset_o = {oh_q, ol_q[15:accr_pkg::LOW_BYTE_LSB]}; // RULE_05
    assign chan4_gain_o = {gh_q, gl_q[15:accr_pkg::LOW_BYTE_LSB]}; // RULE_07

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Stored fields and outputs: reserved bits stay zero, reset values and filter gating hold, and phase, select, offset and gain writes land where the map puts them
    a_setup_reserved: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_02
        (s4_q[5:3] == 3'b000) && (s5_q[5:3] == 3'b000))
        else $error("setup reserved bits not zero");
    a_low_reserved: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_12
        (ol_q[7:0] == 8'h00) && (gl_q[7:0] == 8'h00))
        else $error("low word reserved byte not zero");
    a_phase_field: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_01
        wr_fire && hit_s4 && (avs_byteenable_i[1:0] == 2'b11) |=>
        chan4_phase_delay_o == $past(avs_writedata_i[15:6]))
        else $error("phase field not written");
    a_chan5_phase_delay_field: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_11
        wr_fire && hit_s5 && (avs_byteenable_i[1:0] == 2'b11) |=>
        chan5_phase_delay_o == $past(avs_writedata_i[15:6]))
        else $error("channel 5 phase field not written");
    a_dc_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_03
        chan4_dc_filter_off_o |-> !chan4_dc_filter_active_o)
        else $error("filter active while disabled");
    a_dc_follow: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_03
        !chan5_dc_filter_off_o |-> chan5_dc_filter_active_o == global_dc_filter_setting_i)
        else $error("filter does not follow global setting");
    a_sel_write: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_04
        wr_fire && hit_s5 && avs_byteenable_i[0] |=>
        chan5_input_select_o == $past(avs_writedata_i[1:0]))
        else $error("input select not written");
    a_offset_high: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_05
        wr_fire && hit_oh && (avs_byteenable_i[1:0] == 2'b11) |=>
        chan4_offset_o[23:8] == $past(avs_writedata_i[15:0]))
        else $error("offset high not written");
    a_offset_low: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_06
        wr_fire && hit_ol && avs_byteenable_i[1] |=>
        chan4_offset_o[7:0] == $past(avs_writedata_i[15:8]))
        else $error("offset low not written");
    a_gain_low: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_09
        wr_fire && hit_gl && avs_byteenable_i[1] |=>
        chan4_gain_o[7:0] == $past(avs_writedata_i[15:8]))
        else $error("gain low not written");
    a_gain_high: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_08
        wr_fire && hit_gh && (avs_byteenable_i[1:0] == 2'b11) |=>
        chan4_gain_o[23:8] == $past(avs_writedata_i[15:0]))
        else $error("gain high not written");
    a_gain_reset: assert property (@(posedge ref_clk_i) // RULE_08
        $fell(rst_i) |-> (chan4_gain_o == 24'h800000) && (chan4_offset_o == 24'h000000))
        else $error("calibration reset values wrong");
    a_setup_reset: assert property (@(posedge ref_clk_i) // RULE_10
        $fell(rst_i) |-> (s4_q == 16'h0000) && (s5_q == 16'h0000) && (gl_q == 16'h0000))
        else $error("setup reset values wrong");

    // Bus answers: one wait state, one answer cycle, refused reads return nothing
    a_one_wait: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_10
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("answer late");
    a_answer_once: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_10
        !avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer stands too long");
    a_read_data: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_10
        avs_read_i && !avs_waitrequest_o && addr_ok |-> avs_readdata_o == {16'h0000, rmux})
        else $error("read data does not match addressed word");
    a_refused_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_12
        !avs_waitrequest_o && (avs_response_o == 2'b11) |-> avs_readdata_o == 32'h0000_0000)
        else $error("refused access returned data");
    a_rd_zero_high: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_06
        !avs_waitrequest_o |-> avs_readdata_o[31:16] == 16'h0000)
        else $error("upper read bits not zero");

    c_write_gain: cover property (@(posedge ref_clk_i) disable iff (rst_i) wr_fire && hit_gh);
    c_read_setup: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        avs_read_i && !avs_waitrequest_o && hit_s5);
    c_unmapped: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        !avs_waitrequest_o && avs_response_o == 2'b11);
    c_dc_off: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        global_dc_filter_setting_i && chan4_dc_filter_off_o);
    c_neg_test: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        chan4_input_select_o == 2'b11);

endmodule

// ---- accr_host_model.sv ----
// Avalon-MM host model that runs single register accesses for the bench
`timescale 1ns/1ps
module accr_host_model (
    input wire logic ref_clk_i,
    input wire logic avs_waitrequest_i,
    input wire logic [31:0] avs_readdata_i,
    input wire logic [1:0] avs_response_i,
    output logic [7:0] avs_address_o,
    output logic avs_read_o,
    output logic avs_write_o,
    output logic [31:0] avs_writedata_o,
    output logic [3:0] avs_byteenable_o
);
    // Bus idle from time zero
    initial
    begin
        avs_address_o = 8'h00;
        avs_read_o = 1'b0;
        avs_write_o = 1'b0;
        avs_writedata_o = 32'h0000_0000;
        avs_byteenable_o = 4'h0;
    end

    // ------------------------------------------------------------
    // One access
    // ------------------------------------------------------------
    // Raised after an edge and held until waitrequest is seen low; no latency is assumed
    task automatic access(input logic wr, input logic [7:0] addr, input logic [15:0] data,
        input logic [1:0] be, output logic [31:0] rdata, output logic [1:0] resp);
        @(posedge ref_clk_i);
        avs_address_o <= addr;
        avs_read_o <= ~wr;
        avs_write_o <= wr;
        avs_writedata_o <= {16'h0000, data};
        avs_byteenable_o <= {2'b00, be};
        @(posedge ref_clk_i);
        while (avs_waitrequest_i !== 1'b0)
            @(posedge ref_clk_i);
        rdata = avs_readdata_i;
        resp = avs_response_i;
        avs_read_o <= 1'b0;
        avs_write_o <= 1'b0;
        avs_writedata_o <= ~avs_writedata_o; // Stale data must not look valid
    endtask
endmodule

// ---- accr_regs_tb.sv ----
// Self-checking bench for the channel 4/5 calibration register bank
`timescale 1ns/1ps
module accr_regs_tb;
    logic ref_clk_i;
    logic rst_i = 1'b1;
    logic global_dc_filter_setting_i = 1'b1;
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
    logic [31:0] readdata;
    logic waitrequest;
    logic [1:0] response;
    logic [9:0] c4_phase;
    logic [9:0] c5_phase;
    logic c4_off;
    logic c5_off;
    logic c4_act;
    logic c5_act;
    logic [1:0] c4_sel;
    logic [1:0] c5_sel;
    logic [23:0] c4_ofs;
    logic [23:0] c4_gain;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    logic [31:0] seed = 32'hd846;
    logic [15:0] exp_q [6];
    logic [31:0] rd;
    logic [1:0] rsp;

    accr_regs accr_regs_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address_i(address),
        .avs_read_i(read), .avs_write_i(write), .avs_writedata_i(writedata), .avs_byteenable_i(byteenable),
        .avs_readdata_o(readdata), .avs_waitrequest_o(waitrequest), .avs_response_o(response),
        .global_dc_filter_setting_i(global_dc_filter_setting_i), .chan4_phase_delay_o(c4_phase),
        .chan4_dc_filter_off_o(c4_off), .chan4_dc_filter_active_o(c4_act), .chan4_input_select_o(c4_sel),
        .chan4_offset_o(c4_ofs), .chan4_gain_o(c4_gain), .chan5_phase_delay_o(c5_phase),
        .chan5_dc_filter_off_o(c5_off), .chan5_dc_filter_active_o(c5_act), .chan5_input_select_o(c5_sel));

    accr_host_model accr_host_model_inst (.ref_clk_i(ref_clk_i), .avs_waitrequest_i(waitrequest),
        .avs_readdata_i(readdata), .avs_response_i(response), .avs_address_o(address), .avs_read_o(read),
        .avs_write_o(write), .avs_writedata_o(writedata), .avs_byteenable_o(byteenable));

    // ------------------------------------------------------------
    // Expectation helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Word index 0..5 maps to byte addresses 74h..88h
    function automatic logic [7:0] addr_of(input int i);
        return 8'h74 + 8'(4 * i);
    endfunction

    // Writable bits per word; reserved bits never take a write
    function automatic logic [15:0] mask_of(input int i);
        if (i == 0 || i == 5) return 16'hffc7;
        if (i == 2 || i == 4) return 16'hff00;
        return 16'hffff;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        check_count++;
        if (got !== want)
        begin
            $display("ERROR t=%0t got %h want %h", $time, got, want);
            err_total++;
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Bus and output checks
    // ------------------------------------------------------------
    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (20) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        exp_q = '{16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000};
    endtask

    task automatic wr(input int i, input logic [15:0] d, input logic [1:0] be);
        logic [15:0] m;
        m = mask_of(i) & {{8{be[1]}}, {8{be[0]}}};
        accr_host_model_inst.access(1'b1, addr_of(i), d, be, rd, rsp);
        exp_q[i] = (exp_q[i] & ~m) | (d & m);
        chk({30'h0, rsp}, 32'h0);
    endtask

    task automatic rd_chk(input int i);
        accr_host_model_inst.access(1'b0, addr_of(i), 16'h0000, 2'b11, rd, rsp);
        chk(rd, {16'h0000, exp_q[i]});
        chk({30'h0, rsp}, 32'h0);
    endtask

    // Outputs are looked at mid-cycle, after every edge update has landed
    task automatic out_chk();
        logic g;
        @(negedge ref_clk_i);
        g = global_dc_filter_setting_i;
        chk({18'h0, c4_phase, c4_off, c4_act, c4_sel},
            {18'h0, exp_q[0][15:6], exp_q[0][2], g & ~exp_q[0][2], exp_q[0][1:0]});
        chk({18'h0, c5_phase, c5_off, c5_act, c5_sel},
            {18'h0, exp_q[5][15:6], exp_q[5][2], g & ~exp_q[5][2], exp_q[5][1:0]});
        chk({8'h0, c4_ofs}, {8'h0, exp_q[1], exp_q[2][15:8]});
        chk({8'h0, c4_gain}, {8'h0, exp_q[3], exp_q[4][15:8]});
    endtask

    // ------------------------------------------------------------
    // Clock, timeout and main sequence
    // ------------------------------------------------------------
    initial
    begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    // About 2050 cycles are needed; the ceiling leaves ample margin
    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            err_total++;
            close_out();
        end
    end

    initial
    begin
        logic [31:0] r;
        logic [31:0] d;
        logic [1:0] be;
        // Second pass resets with every word dirty, to prove reset restores all
        for (int pass = 0; pass < 2; pass++)
        begin
            do_reset();
            out_chk();
            for (int i = 0; i < 6; i++)
                rd_chk(i);
            for (int i = 0; i < 6; i++)
            begin
                wr(i, 16'hffff, 2'b11);
                rd_chk(i);
            end
            for (int k = 0; k < 4; k++)
            begin
                wr(0, {14'h0, 2'(k)}, 2'b01);
                wr(5, {14'h0, 2'(3 - k)}, 2'b01);
                out_chk();
            end
            for (int n = 0; n < 150; n++)
            begin
                r = rnd();
                d = rnd();
                be = (r[3:2] == 2'b00) ? r[1:0] : 2'b11;
                wr(int'(r[31:16] % 16'd6), d[15:0], be);
                global_dc_filter_setting_i <= r[4];
                rd_chk(int'(r[31:16] % 16'd6));
                out_chk();
            end
            // Unmapped and misaligned accesses are refused and change nothing
            accr_host_model_inst.access(1'b1, 8'h8c, 16'hffff, 2'b11, rd, rsp);
            chk({30'h0, rsp}, 32'h3);
            accr_host_model_inst.access(1'b1, 8'h79, 16'h5a5a, 2'b11, rd, rsp);
            chk({30'h0, rsp}, 32'h3);
            accr_host_model_inst.access(1'b0, 8'h75, 16'h0000, 2'b11, rd, rsp);
            chk(rd, 32'h0000_0000);
            chk({30'h0, rsp}, 32'h3);
            for (int i = 0; i < 6; i++)
                rd_chk(i);
        end
        close_out();
    end
endmodule
